/* File: core/mefs_pkg.sv */
// Shared constants and state type for the motion event source flag block
package mefs_pkg;

	// Widths
	localparam int unsigned DATA_W  = 8;
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned ACCEL_W = 10;
	localparam int unsigned THS_W   = 7;
	localparam int unsigned AXES    = 3;

	// Register offsets
	localparam logic [7:0] ADDR_CFG = 8'h15;
	localparam logic [7:0] ADDR_SRC = 8'h16;
	localparam logic [7:0] ADDR_THS = 8'h17;

	// Configuration register field positions
	localparam int unsigned CFG_LATCH_BIT  = 7;
	localparam int unsigned CFG_OR_AND_BIT = 6;
	localparam int unsigned CFG_ZEN_BIT = 5;
	localparam int unsigned CFG_YEN_BIT = 4;
	localparam int unsigned CFG_XEN_BIT = 3;

	// Source register field positions; bit 6 always reads zero
	localparam int unsigned SRC_ACTIVE_BIT = 7;
	localparam int unsigned SRC_ZF_BIT = 5;
	localparam int unsigned SRC_ZP_BIT = 4;
	localparam int unsigned SRC_YF_BIT = 3;
	localparam int unsigned SRC_YP_BIT = 2;
	localparam int unsigned SRC_XF_BIT = 1;
	localparam int unsigned SRC_XP_BIT = 0;

	// Values after reset
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [6:0] RST_THS  = 7'h00;
	localparam logic       RST_BIT  = 1'b0;
	localparam logic [2:0] RST_AXES = 3'h0;

	// Axis index into the per-axis vectors
	localparam int unsigned AX_X = 0;
	localparam int unsigned AX_Y = 1;
	localparam int unsigned AX_Z = 2;

	typedef struct packed {
		logic       event_latch_enable;
		logic       or_and_select;
		logic [2:0] en;
		logic [6:0] ths;
		logic       event_active_flag;
		logic [2:0] flag;
		logic [2:0] pol;
		logic [7:0] rdata;
	} mefs_state_t;

	// Unsigned magnitude of a two's-complement sample
	function automatic logic [9:0] mefs_mag(input logic [9:0] a);
		mefs_mag = a[9] ? 10'((~a) + 10'h001) : a;
	endfunction

endpackage

/* File: core/mefs_axis_cmp.sv */
// Per-axis threshold comparison for the motion event source flags
`timescale 1ns/1ps
module mefs_axis_cmp (
	// Sample and settings
	input  wire logic [9:0] i_accel,
	input  wire logic [6:0] i_ths,
	input  wire logic       i_en,
	input  wire logic       i_or_mode,
	// Result
	output logic            o_hit,
	output logic            o_negative
);

	logic [9:0] mag;
	logic       above;

	always_comb begin
		mag = mefs_pkg::mefs_mag(i_accel);
		// Threshold is unsigned and compared against the magnitude
		above = (mag > {3'h0, i_ths});
		// Motion wants above, freefall wants at or below
		o_hit = i_en & (i_or_mode ? above : ~above);
		o_negative = i_accel[9];
	end

endmodule // mefs_axis_cmp

/* File: core/mefs_combine.sv */
// Summary event combination across the enabled axes
`timescale 1ns/1ps
module mefs_combine (
	// Axis results
	input  wire logic [2:0] i_hit,
	input  wire logic [2:0] i_en,
	input  wire logic       i_or_mode,
	// Summary
	output logic            o_active
);

	logic any_hit;
	logic all_hit;

	always_comb begin
		any_hit = |(i_hit & i_en);
		// Disabled axes do not block the AND; no enabled axis means no event
		all_hit = (&(i_hit | ~i_en)) & (|i_en);
		o_active = i_or_mode ? any_hit : all_hit;
	end

endmodule // mefs_combine

/* File: core/mefs_top.sv */
// Motion event source flags with their configuration and register port
//
// How it works
// - Summary flag high when any (OR) or every (AND) enabled axis flag asserted, low otherwise.
// - Z motion flag is one on a detected Z event, else zero.
// - Z motion flag reads zero while Z detection is disabled.
// - Z polarity flag is zero for positive, one for negative acceleration.
// - Z polarity flag reads zero while Z detection is disabled.
// - Y motion flag is one on a detected Y event, else zero.
// - Y motion flag reads zero while Y detection is disabled.
// - Y polarity flag is zero for positive, one for negative acceleration.
// - Y polarity flag reads zero while Y detection is disabled.
// - X motion flag is one on a detected X event, else zero.
// - X motion flag reads zero while X detection is disabled.
// - X polarity flag is zero for positive, one for negative acceleration.
// - All axis, polarity and summary flags reset to zero.
// - Summary uses OR for motion or AND for freefall per select bit.
// - With latching, flags freeze once summary sets; source read clears.
// - Motion is magnitude above threshold; freefall is at or below it.
`timescale 1ns/1ps
module mefs_top (
	// Clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_b,
	// Acceleration samples from the datapath, same clock
	input  wire logic       i_sample_valid,
	input  wire logic [9:0] i_x_accel,
	input  wire logic [9:0] i_y_accel,
	input  wire logic [9:0] i_z_accel,
	// Register port
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	output logic      [7:0] o_rdata,
	// Flags
	output logic            o_event_active_flag,
	output logic            o_z_motion_flag,
	output logic            o_z_polarity_flag,
	output logic            o_y_motion_flag,
	output logic            o_y_polarity_flag,
	output logic            o_x_motion_flag,
	output logic            o_x_polarity_flag
);

	mefs_pkg::mefs_state_t st_r;
	mefs_pkg::mefs_state_t st_nxt;

	logic [2:0] hit;
	logic [2:0] neg;
	logic       active;
	logic [7:0] src_byte;
	logic [7:0] cfg_byte;
	logic       src_read;
	logic       frozen;

	mefs_axis_cmp u_cmp_x (
		.i_accel    (i_x_accel),
		.i_ths      (st_r.ths),
		.i_en       (st_r.en[mefs_pkg::AX_X]),
		.i_or_mode  (st_r.or_and_select),
		.o_hit      (hit[mefs_pkg::AX_X]),
		.o_negative (neg[mefs_pkg::AX_X])
	);

	mefs_axis_cmp u_cmp_y (
		.i_accel    (i_y_accel),
		.i_ths      (st_r.ths),
		.i_en       (st_r.en[mefs_pkg::AX_Y]),
		.i_or_mode  (st_r.or_and_select),
		.o_hit      (hit[mefs_pkg::AX_Y]),
		.o_negative (neg[mefs_pkg::AX_Y])
	);

	mefs_axis_cmp u_cmp_z (
		.i_accel    (i_z_accel),
		.i_ths      (st_r.ths),
		.i_en       (st_r.en[mefs_pkg::AX_Z]),
		.i_or_mode  (st_r.or_and_select),
		.o_hit      (hit[mefs_pkg::AX_Z]),
		.o_negative (neg[mefs_pkg::AX_Z])
	);

	mefs_combine u_comb (
		.i_hit     (hit),
		.i_en      (st_r.en),
		.i_or_mode (st_r.or_and_select),
		.o_active  (active)
	);

	always_comb begin
		src_byte = mefs_pkg::RST_DATA;
		src_byte[mefs_pkg::SRC_ACTIVE_BIT] = st_r.event_active_flag;
		src_byte[mefs_pkg::SRC_ZF_BIT] = st_r.flag[mefs_pkg::AX_Z];
		src_byte[mefs_pkg::SRC_ZP_BIT] = st_r.pol[mefs_pkg::AX_Z];
		src_byte[mefs_pkg::SRC_YF_BIT] = st_r.flag[mefs_pkg::AX_Y];
		src_byte[mefs_pkg::SRC_YP_BIT] = st_r.pol[mefs_pkg::AX_Y];
		src_byte[mefs_pkg::SRC_XF_BIT] = st_r.flag[mefs_pkg::AX_X];
		src_byte[mefs_pkg::SRC_XP_BIT] = st_r.pol[mefs_pkg::AX_X];

		cfg_byte = mefs_pkg::RST_DATA;
		cfg_byte[mefs_pkg::CFG_LATCH_BIT]  = st_r.event_latch_enable;
		cfg_byte[mefs_pkg::CFG_OR_AND_BIT] = st_r.or_and_select;
		cfg_byte[mefs_pkg::CFG_ZEN_BIT] = st_r.en[mefs_pkg::AX_Z];
		cfg_byte[mefs_pkg::CFG_YEN_BIT] = st_r.en[mefs_pkg::AX_Y];
		cfg_byte[mefs_pkg::CFG_XEN_BIT] = st_r.en[mefs_pkg::AX_X];

		src_read = i_rd_en & (i_addr == mefs_pkg::ADDR_SRC);
		// Latched flags stay put until software has seen them
		frozen = st_r.event_latch_enable
			& st_r.event_active_flag;
	end

	always_comb begin
		st_nxt = st_r;

		// Configuration writes
		if (i_wr_en) begin
			case (i_addr)
				mefs_pkg::ADDR_CFG: begin
					st_nxt.event_latch_enable =
						i_wdata[mefs_pkg::CFG_LATCH_BIT];
					st_nxt.or_and_select =
						i_wdata[mefs_pkg::CFG_OR_AND_BIT];
					st_nxt.en[mefs_pkg::AX_Z] = i_wdata[mefs_pkg::CFG_ZEN_BIT];
					st_nxt.en[mefs_pkg::AX_Y] = i_wdata[mefs_pkg::CFG_YEN_BIT];
					st_nxt.en[mefs_pkg::AX_X] = i_wdata[mefs_pkg::CFG_XEN_BIT];
				end
				mefs_pkg::ADDR_THS: begin
					st_nxt.ths = i_wdata[6:0];
				end
				default: begin
					st_nxt.ths = st_r.ths;
				end
			endcase
		end

		// Read data, shown the cycle after the strobe; unmapped reads zero
		st_nxt.rdata = mefs_pkg::RST_DATA;
		if (i_rd_en) begin
			case (i_addr)
				mefs_pkg::ADDR_CFG: st_nxt.rdata = cfg_byte;
				mefs_pkg::ADDR_SRC: st_nxt.rdata = src_byte;
				mefs_pkg::ADDR_THS: st_nxt.rdata = {1'b0, st_r.ths};
				default:            st_nxt.rdata = mefs_pkg::RST_DATA;
			endcase
		end

		// A latched source read clears; a sample in that cycle still lands
		if (st_r.event_latch_enable && src_read) begin
			st_nxt.event_active_flag = 1'b0;
			st_nxt.flag = mefs_pkg::RST_AXES;
			st_nxt.pol  = mefs_pkg::RST_AXES;
		end
		if (!st_r.event_latch_enable) begin
			// Real-time mode: flags follow the last sample with no hold
			if (i_sample_valid) begin
				st_nxt.flag = hit;
				st_nxt.pol  = hit & neg;
				st_nxt.event_active_flag = active;
			end
		end else if (i_sample_valid && (!frozen || src_read)) begin
			// Set wins over the clear of a read in the same cycle
			st_nxt.flag = hit;
			st_nxt.pol  = hit & neg;
			st_nxt.event_active_flag = active;
		end

		// Disabled axes read zero whatever was captured
		st_nxt.flag = st_nxt.flag & st_nxt.en;
		st_nxt.pol  = st_nxt.pol & st_nxt.en;
		if (st_nxt.flag == mefs_pkg::RST_AXES) begin
			// No enabled axis flag left standing: summary must drop
			st_nxt.event_active_flag = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			st_r.event_latch_enable <= mefs_pkg::RST_BIT;
			st_r.or_and_select      <= mefs_pkg::RST_BIT;
			st_r.en                 <= mefs_pkg::RST_AXES;
			st_r.ths                <= mefs_pkg::RST_THS;
			st_r.event_active_flag  <= mefs_pkg::RST_BIT;
			st_r.flag               <= mefs_pkg::RST_AXES;
			st_r.pol                <= mefs_pkg::RST_AXES;
			st_r.rdata <= mefs_pkg::RST_DATA;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata             = st_r.rdata;
	assign o_event_active_flag = st_r.event_active_flag;
	assign o_z_motion_flag     = st_r.flag[mefs_pkg::AX_Z];
	assign o_z_polarity_flag   = st_r.pol[mefs_pkg::AX_Z];
	assign o_y_motion_flag     = st_r.flag[mefs_pkg::AX_Y];
	assign o_y_polarity_flag   = st_r.pol[mefs_pkg::AX_Y];
	assign o_x_motion_flag     = st_r.flag[mefs_pkg::AX_X];
	assign o_x_polarity_flag   = st_r.pol[mefs_pkg::AX_X];

endmodule // mefs_top

/* File: sim/mefs_chk_assertions.sv */
// Port-level assertions for the motion event source flag block
`timescale 1ns/1ps
module mefs_chk_assertions (
	// Clock, reset and sample
	input wire logic       i_ref_clk,
	input wire logic       i_rst_b,
	input wire logic       i_sample_valid,
	input wire logic [9:0] i_x_accel,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr_en,
	input wire logic       i_rd_en,
	input wire logic [7:0] o_rdata,
	// Flags
	input wire logic       o_event_active_flag,
	input wire logic       o_z_motion_flag,
	input wire logic       o_z_polarity_flag,
	input wire logic       o_y_motion_flag,
	input wire logic       o_y_polarity_flag,
	input wire logic       o_x_motion_flag,
	input wire logic       o_x_polarity_flag
);
	logic [7:0] src;
	logic [2:0] hit;
	logic [2:0] pol;
	logic [9:0] mag;
	logic [7:0] cfg_r;
	logic [6:0] ths_r;
	assign src = {o_event_active_flag, 1'b0, o_z_motion_flag,
		o_z_polarity_flag, o_y_motion_flag, o_y_polarity_flag,
		o_x_motion_flag, o_x_polarity_flag};
	assign hit = {src[5], src[3], src[1]};
	assign pol = {src[4], src[2], src[0]};
	assign mag = i_x_accel[9] ? 10'(~i_x_accel + 10'h001) : i_x_accel;
	// Shadow of the settings, taken from the bus like the design does
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			cfg_r <= 8'h00;
			ths_r <= 7'h00;
		end else if (i_wr_en && i_addr == mefs_pkg::ADDR_CFG) begin
			cfg_r <= i_wdata;
		end else if (i_wr_en && i_addr == mefs_pkg::ADDR_THS) begin
			ths_r <= i_wdata[6:0];
		end
	end
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	property p_rst;
		disable iff (1'b0) !i_rst_b |=> src == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("flags not cleared");
	property p_off;
		((hit | pol) & ~(cfg_r[5:3] | $past(cfg_r[5:3]))) == 3'b000;
	endproperty
	a_off: assert property (p_off) else $error("disabled axis flag");
	property p_pol;
		(pol & ~hit) == 3'b000;
	endproperty
	a_pol: assert property (p_pol) else $error("polarity w/o event");
	property p_ea_flag;
		src[7] |-> hit != 3'b000;
	endproperty
	a_ea_flag: assert property (p_ea_flag) else $error("summary w/o flag");
	property p_xhit;
		i_sample_valid && cfg_r[6] && cfg_r[3] && !cfg_r[7] && !i_wr_en
		&& mag > {3'b000, ths_r} |=> src[1] && src[0] == $past(i_x_accel[9]);
	endproperty
	a_xhit: assert property (p_xhit) else $error("x event wrong");
	property p_ea_or;
		i_sample_valid && cfg_r[6] && !cfg_r[7] && !i_wr_en |=> src[7] == |hit;
	endproperty
	a_ea_or: assert property (p_ea_or) else $error("summary OR wrong");
	property p_ea_and;
		i_sample_valid && !cfg_r[6] && !cfg_r[7] && !i_wr_en |=> src[7] ==
		(&(hit | ~$past(cfg_r[5:3])) && |$past(cfg_r[5:3]));
	endproperty
	a_ea_and: assert property (p_ea_and) else $error("summary AND wrong");
	property p_rdata;
		i_rd_en && i_addr == mefs_pkg::ADDR_SRC |=> o_rdata == $past(src);
	endproperty
	a_rdata: assert property (p_rdata) else $error("source read wrong");
	property p_latch;
		cfg_r[7] && src[7] && !i_wr_en && !i_rd_en |=> $stable(src);
	endproperty
	a_latch: assert property (p_latch) else $error("latched flags moved");
	c_latch: cover property (cfg_r[7] && src[7]);
	c_and: cover property (!cfg_r[6] && src[7]);
	c_neg: cover property (o_z_polarity_flag);
endmodule // mefs_chk_assertions

/* File: sim/mefs_host_model.sv */
// Host model driving the register port of the flag block
`timescale 1ns/1ps
module mefs_host_model (
	// Clock and read data
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_rdata,
	// Register port
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr_en,
	output logic            o_rd_en
);
	initial {o_addr, o_wdata, o_wr_en, o_rd_en} = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_wr_en <= 1'b1;
		o_addr  <= a;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_wr_en <= 1'b0;
	endtask
	// Read data only stand in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_rd_en <= 1'b1;
		o_addr  <= a;
		@(posedge i_ref_clk);
		o_rd_en <= 1'b0;
		#1 d = i_rdata;
	endtask
endmodule // mefs_host_model

/* File: sim/test_mefs_top.sv */
// Self-checking bench for the motion event source flag block
`timescale 1ns/1ps
module test_mefs_top;
	logic       i_ref_clk = 1'b0;
	logic       i_rst_b = 1'b0;
	logic       i_sample_valid = 1'b0;
	logic [9:0] i_x_accel = '0;
	logic [9:0] i_y_accel = '0;
	logic [9:0] i_z_accel = '0;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic       i_wr_en, i_rd_en;
	logic       o_event_active_flag, o_z_motion_flag, o_z_polarity_flag;
	logic       o_y_motion_flag, o_y_polarity_flag, o_x_motion_flag;
	logic       o_x_polarity_flag;
	int         n_mismatch = 0;
	int         samples_checked = 0;
	always #2 i_ref_clk = ~i_ref_clk;
	mefs_top mefs_top_inst (.i_ref_clk, .i_rst_b, .i_sample_valid,
		.i_x_accel, .i_y_accel, .i_z_accel, .i_addr, .i_wdata, .i_wr_en,
		.i_rd_en, .o_rdata, .o_event_active_flag, .o_z_motion_flag,
		.o_z_polarity_flag, .o_y_motion_flag, .o_y_polarity_flag,
		.o_x_motion_flag, .o_x_polarity_flag);
	mefs_host_model h (.i_ref_clk, .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		h.rd(a, d);
		chk(d, exp);
	endtask
	// Flag pins are looked at once the launching edge has settled
	task automatic pinc(input logic [7:0] exp);
		#1 chk({o_event_active_flag, 1'b0, o_z_motion_flag,
			o_z_polarity_flag, o_y_motion_flag, o_y_polarity_flag,
			o_x_motion_flag, o_x_polarity_flag}, exp);
	endtask
	task automatic smp(input logic [9:0] x, input logic [9:0] y,
		input logic [9:0] z);
		@(posedge i_ref_clk);
		i_sample_valid <= 1'b1;
		{i_x_accel, i_y_accel, i_z_accel} <= {x, y, z};
		@(posedge i_ref_clk);
		i_sample_valid <= 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		rdc(8'h16, 8'h00);
		h.wr(8'h17, 8'h0A);
		h.wr(8'h15, 8'h78);
		smp(10'h338, 10'h0C8, 10'h005);
		pinc(8'h8B);
		rdc(8'h16, 8'h8B);
		smp(10'h000, 10'h000, 10'h3F5);
		rdc(8'h16, 8'hB0);
		smp(10'h000, 10'h000, 10'h3F6);
		rdc(8'h16, 8'h00);
		// Negative event on each axis in turn, then that axis disabled
		for (int i = 0; i < 3; i++) begin
			h.wr(8'h15, 8'h78);
			smp(i == 0 ? 10'h338 : 10'h000, i == 1 ? 10'h338 : 10'h000,
				i == 2 ? 10'h338 : 10'h000);
			rdc(8'h16, 8'h80 | (8'h03 << 2 * i));
			h.wr(8'h15, 8'h78 & ~(8'h08 << i));
			rdc(8'h16, 8'h00);
		end
		h.wr(8'h15, 8'h38);
		smp(10'h3FB, 10'h000, 10'h00A);
		rdc(8'h16, 8'hAB);
		smp(10'h00B, 10'h000, 10'h000);
		rdc(8'h16, 8'h28);
		h.wr(8'h15, 8'hF8);
		smp(10'h338, 10'h000, 10'h000);
		smp(10'h000, 10'h0C8, 10'h000);
		pinc(8'h83);
		rdc(8'h16, 8'h83);
		pinc(8'h00);
		rdc(8'h16, 8'h00);
		h.wr(8'h16, 8'hFF);
		rdc(8'h16, 8'h00);
		rdc(8'h17, 8'h0A);
		rdc(8'h15, 8'hF8);
		rdc(8'h20, 8'h00);
		// Reset in mid-run while flags stand
		h.wr(8'h15, 8'h78);
		smp(10'h338, 10'h000, 10'h000);
		@(posedge i_ref_clk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		pinc(8'h00);
		rdc(8'h15, 8'h00);
		rdc(8'h16, 8'h00);
		tally_and_finish;
	end
	initial begin
		repeat (2000) @(posedge i_ref_clk);
		n_mismatch++;
		tally_and_finish;
	end
endmodule // test_mefs_top
bind mefs_top mefs_chk_assertions mefs_chk_assertions_inst (.i_ref_clk,
	.i_rst_b, .i_sample_valid, .i_x_accel, .i_addr, .i_wdata, .i_wr_en,
	.i_rd_en, .o_rdata, .o_event_active_flag, .o_z_motion_flag,
	.o_z_polarity_flag, .o_y_motion_flag, .o_y_polarity_flag,
	.o_x_motion_flag, .o_x_polarity_flag);
